/* rtl/tx_chain_pkg.sv */
// package for the transmit mixer / correction / alignment chain
// assumes one 40 MHz sample clock and documented-pin register access
package tx_chain_pkg;
    localparam int SAMPLE_W = 12;
    localparam int NCO_FREQ_W = 32;
    localparam int NCO_PHASE_W = 20;
    localparam int GAIN_W = 11;
    localparam int SKEW_W = 10;
    localparam int SHIFT_W = 13;
    localparam int LUT_ADDR_W = 8;
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_PTR_W = 3;
    localparam logic [FIFO_PTR_W-1:0] FIFO_RD_SYNC_PTR = 3'h4;
    localparam logic [FIFO_PTR_W-1:0] FIFO_WR_SYNC_PTR = 3'h0;
    localparam logic [GAIN_W-1:0] GAIN_RESET = 11'h400;
    localparam logic [SKEW_W-1:0] SKEW_RESET = 10'h000;
    localparam logic [SHIFT_W-1:0] SHIFT_RESET = 13'h0000;
    localparam int GAIN_FRAC = 10;
    localparam int SKEW_FRAC = 12;
    localparam int SHIFT_FRAC = 4;
    localparam int SINC_FRAC = 9;
    // inverse-droop taps, symmetric about the centre one
    localparam logic signed [11:0] SINC_C0 = 12'sh001;
    localparam logic signed [11:0] SINC_C1 = -12'sh004;
    localparam logic signed [11:0] SINC_C2 = 12'sh00D;
    localparam logic signed [11:0] SINC_C3 = -12'sh032;
    localparam logic signed [11:0] SINC_C4 = 12'sh250;

    typedef enum logic [1:0] {
        COARSE_MIXER_PASS, COARSE_MIXER_HALF, COARSE_MIXER_PLUS_QTR, COARSE_MIXER_MINUS_QTR
    } coarse_mode_t;

    typedef struct packed {
        logic signed [SAMPLE_W-1:0] a;
        logic signed [SAMPLE_W-1:0] b;
    } iq_sample_t;

    typedef struct packed {
        logic [GAIN_W-1:0] i_path_gain;
        logic [GAIN_W-1:0] q_path_gain;
        logic [SKEW_W-1:0] iq_phase_skew;
        logic [SHIFT_W-1:0] a_path_dc_shift;
        logic [SHIFT_W-1:0] b_path_dc_shift;
        logic [NCO_FREQ_W-1:0] nco_freq;
        logic [NCO_PHASE_W-1:0] nco_phase;
        logic [1:0] coarse_mode;
        logic [1:0] coarse_phase;
    } chain_cfg_t;

    typedef struct packed {
        logic tx_align_all_disable;
        logic tx_align_source_select;
        logic tx_align_reg_bit;
        logic fifo_align_reg_bit;
        logic corr_align_reg_bit;
        logic nco_align_reg_bit;
        logic coarse_mixer_align_reg_bit;
        logic shift_align_reg_bit;
        logic shift_needs_align;
        logic block_use_pin;
    } align_ctrl_t;
endpackage

/* rtl/sample_fifo.sv */
// small sample FIFO with valid/ready on both sides
// assumes one clock; an align clears write pointer and sets read pointer
`timescale 1ns/10ps
module sample_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 4
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_align,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    import tx_chain_pkg::*;
    localparam int PW = $clog2(DEPTH) + 1;
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0] wr_ff;
    logic [PW-1:0] rd_ff;
    logic [PW-1:0] fill;
    logic push;
    logic pop;

    assign fill = PW'(wr_ff - rd_ff);
    assign o_in_ready = fill < PW'(DEPTH);
    assign o_out_valid = fill != '0;
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = mem_ff[rd_ff[PW-2:0]];

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ff <= '0;
            rd_ff <= '0;
        end else if (i_align) begin
            // pointers reset a fixed four apart; stored words become the fill
            wr_ff <= PW'(FIFO_WR_SYNC_PTR); // [RULE19]
            rd_ff <= PW'(FIFO_RD_SYNC_PTR); // [RULE19]
        end else begin
            if (push) wr_ff <= PW'(wr_ff + 1'b1);
            if (pop) rd_ff <= PW'(rd_ff + 1'b1);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (push && !i_align) mem_ff[wr_ff[PW-2:0]] <= i_in_data;
    end
endmodule // sample_fifo

/* rtl/tx_mixer_qmc_sync_chain.sv */
// transmit chain: fifo, fine mixer, coarse mixer, inverse droop, iq correction, dc shift
// assumes settings arrive on documented pins; align pin is asynchronous
`timescale 1ns/10ps
// Summary of operation
// [RULE1] 32-bit tuning word, 20-bit phase offset
// [RULE2] fine mixer complex multiply by oscillator
// [RULE3] tuning spans +-fs/2 in fs/2^32 steps
// [RULE4] coarse mode 00 passes A and B
// [RULE5] coarse mode 01 negates alternate samples
// [RULE6] coarse mode 10 rotates plus quarter rate
// [RULE7] coarse mode 11 rotates minus quarter rate
// [RULE8] symmetric nine-tap inverse droop filter
// [RULE9] source backs off amplitude before filter
// [RULE10] gains are eleven-bit words over 1024
// [RULE11] signed skew times Q added to I
// [RULE12] thirteen-bit dc shift divided by sixteen
// [RULE13] dc shift added lsb aligned before DAC
// [RULE14] global align default, pin rising edge
// [RULE15] register bit rising edge as source
// [RULE16] global disabled: per-block align controls
// [RULE17] dc shift immediate unless align needed
// [RULE18] controller aligns divider, fifo, then rest; no controller here, a global align hits every block in the same cycle
// [RULE19] align: write pointer zero, read four
// [RULE20] align loads gain and skew settings
// [RULE21] align loads oscillator, accumulator to phase
// [RULE22] align restarts coarse pattern at phase
// [RULE23] accumulator adds tuning word each sample
module tx_mixer_qmc_sync_chain (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_align_in_pos,
    input wire tx_chain_pkg::chain_cfg_t i_cfg,
    input wire tx_chain_pkg::align_ctrl_t i_align_ctrl,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire tx_chain_pkg::iq_sample_t i_in_sample,
    output logic o_out_valid,
    output tx_chain_pkg::iq_sample_t o_out_sample,
    output logic o_align_seen
);
    import tx_chain_pkg::*;
    localparam int SW = SAMPLE_W;
    localparam int WW = 32;

    // ---------------- align source selection ----------------
    logic [2:0] pin_sync_ff;
    logic pin_level_ff;
    logic pin_rise;
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_sync_ff <= 3'h0;
            pin_level_ff <= 1'b0;
        end else begin
            pin_sync_ff <= {pin_sync_ff[1:0], i_align_in_pos};
            if (pin_sync_ff[1] == pin_sync_ff[2]) pin_level_ff <= pin_sync_ff[2];
        end
    end
    assign pin_rise = pin_sync_ff[1] && pin_sync_ff[2] && !pin_level_ff;

    logic [5:0] bits_prev_ff;
    logic [5:0] bits_now;
    logic [5:0] bit_rise;
    assign bits_now = {i_align_ctrl.tx_align_reg_bit, i_align_ctrl.fifo_align_reg_bit,
                       i_align_ctrl.corr_align_reg_bit, i_align_ctrl.nco_align_reg_bit,
                       i_align_ctrl.coarse_mixer_align_reg_bit, i_align_ctrl.shift_align_reg_bit};
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) bits_prev_ff <= 6'h00;
        else bits_prev_ff <= bits_now;
    end
    assign bit_rise = bits_now & ~bits_prev_ff; // [RULE15]

    logic global_evt;
    logic blk_pin;
    logic fifo_align;
    logic corr_align;
    logic nco_align;
    logic coarse_mixer_align;
    logic shift_align;
    // zero struct fields mean global pin mode, so reset defaults to it
    assign global_evt = i_align_ctrl.tx_align_source_select ? bit_rise[5] : pin_rise; // [RULE14]
    assign blk_pin = i_align_ctrl.block_use_pin && pin_rise;
    always_comb begin
        if (!i_align_ctrl.tx_align_all_disable) begin
            fifo_align = global_evt; // [RULE14]
            corr_align = global_evt;
            nco_align = global_evt;
            coarse_mixer_align = global_evt;
            shift_align = global_evt;
        end else begin
            fifo_align = blk_pin || bit_rise[4]; // [RULE16]
            corr_align = blk_pin || bit_rise[3];
            nco_align = blk_pin || bit_rise[2];
            coarse_mixer_align = blk_pin || bit_rise[1];
            shift_align = blk_pin || bit_rise[0];
        end
    end

    logic align_seen_ff;
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) align_seen_ff <= 1'b0;
        else if (fifo_align || corr_align || nco_align || coarse_mixer_align || shift_align)
            align_seen_ff <= 1'b1;
    end
    assign o_align_seen = align_seen_ff;

    // ---------------- fifo ----------------
    iq_sample_t fifo_out;
    logic fifo_valid;
    sample_fifo #(.WIDTH(2 * SW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_align(fifo_align),
        .i_in_valid(i_in_valid),
        .o_in_ready(o_in_ready),
        .i_in_data(i_in_sample),
        .o_out_valid(fifo_valid),
        .i_out_ready(1'b1),
        .o_out_data(fifo_out)
    );
    // the pipeline below never stalls; each popped sample is one sample tick
    logic adv;
    assign adv = fifo_valid;

    // ---------------- active settings ----------------
    logic [NCO_FREQ_W-1:0] freq_ff; // [RULE1]
    logic [NCO_PHASE_W-1:0] phase_ff; // [RULE1]
    logic [NCO_FREQ_W-1:0] acc_ff;
    logic [GAIN_W-1:0] gain_i_ff;
    logic [GAIN_W-1:0] gain_q_ff;
    logic [SKEW_W-1:0] skew_ff;
    logic [SHIFT_W-1:0] shift_a_ff;
    logic [SHIFT_W-1:0] shift_b_ff;
    logic [1:0] coarse_mixer_cnt_ff;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            freq_ff <= '0;
            phase_ff <= '0;
            acc_ff <= '0;
        end else if (nco_align) begin
            freq_ff <= i_cfg.nco_freq; // [RULE21]
            phase_ff <= i_cfg.nco_phase; // [RULE21]
            acc_ff <= {i_cfg.nco_phase, 12'h000}; // [RULE21]
        end else if (adv) begin
            acc_ff <= acc_ff + freq_ff; // [RULE23] [RULE3]
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gain_i_ff <= GAIN_RESET;
            gain_q_ff <= GAIN_RESET;
            skew_ff <= SKEW_RESET;
        end else if (corr_align) begin
            gain_i_ff <= i_cfg.i_path_gain; // [RULE20]
            gain_q_ff <= i_cfg.q_path_gain; // [RULE20]
            skew_ff <= i_cfg.iq_phase_skew; // [RULE20]
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shift_a_ff <= SHIFT_RESET;
            shift_b_ff <= SHIFT_RESET;
        end else if (!i_align_ctrl.shift_needs_align || shift_align) begin
            shift_a_ff <= i_cfg.a_path_dc_shift; // [RULE17]
            shift_b_ff <= i_cfg.b_path_dc_shift; // [RULE17]
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) coarse_mixer_cnt_ff <= 2'h0;
        else if (coarse_mixer_align) coarse_mixer_cnt_ff <= i_cfg.coarse_phase; // [RULE22]
        else if (adv) coarse_mixer_cnt_ff <= coarse_mixer_cnt_ff + 2'h1;
    end

    // ---------------- fine mixer ----------------
    // full-wave 256-entry sine table built by a constant function; 8-bit phase is a
    // spur-for-area trade, the accumulator keeps full 32-bit resolution
    function automatic logic signed [SW-1:0] sin_lut(input logic [LUT_ADDR_W-1:0] ph);
        real x;
        x = $sin(2.0 * 3.14159265358979 * real'(ph) / 256.0) * 2047.0;
        return SW'($rtoi(x));
    endfunction
    logic signed [SW-1:0] sin_tab [256];
    for (genvar g = 0; g < 256; g++) begin : g_lut
        assign sin_tab[g] = sin_lut(LUT_ADDR_W'(g));
    end

    logic [NCO_FREQ_W-1:0] lut_phase;
    logic signed [SW-1:0] sin_v;
    logic signed [SW-1:0] cos_v;
    assign lut_phase = acc_ff + {phase_ff, 12'h000}; // [RULE23]
    assign sin_v = sin_tab[lut_phase[31:24]];
    assign cos_v = sin_tab[8'(lut_phase[31:24] + 8'h40)];

    function automatic logic signed [SW-1:0] sat(input logic signed [WW-1:0] v);
        if (v > WW'(2047)) return 12'sh7FF;
        if (v < -WW'(2048)) return -12'sh800;
        return v[SW-1:0];
    endfunction

    iq_sample_t fine_ff;
    logic fine_v_ff;
    logic signed [WW-1:0] mi;
    logic signed [WW-1:0] mq;
    always_comb begin
        mi = WW'(fifo_out.a * cos_v) - WW'(fifo_out.b * sin_v); // [RULE2]
        mq = WW'(fifo_out.a * sin_v) + WW'(fifo_out.b * cos_v); // [RULE2]
    end
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fine_ff <= '0;
            fine_v_ff <= 1'b0;
        end else begin
            fine_v_ff <= adv;
            if (adv) begin
                fine_ff.a <= sat(mi >>> 11);
                fine_ff.b <= sat(mq >>> 11);
            end
        end
    end

    // ---------------- coarse mixer ----------------
    logic [1:0] cm_cnt_d_ff;
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) cm_cnt_d_ff <= 2'h0;
        else if (adv) cm_cnt_d_ff <= coarse_mixer_cnt_ff;
    end

    function automatic logic signed [SW-1:0] neg(input logic signed [SW-1:0] v);
        return (v == -12'sh800) ? 12'sh7FF : -v;
    endfunction

    iq_sample_t cm;
    always_comb begin
        cm = fine_ff;
        case (coarse_mode_t'(i_cfg.coarse_mode))
            COARSE_MIXER_PASS: cm = fine_ff; // [RULE4]
            COARSE_MIXER_HALF: begin
                if (cm_cnt_d_ff[0]) begin
                    cm.a = neg(fine_ff.a); // [RULE5]
                    cm.b = neg(fine_ff.b); // [RULE5]
                end
            end
            COARSE_MIXER_PLUS_QTR: begin
                case (cm_cnt_d_ff)
                    2'h0: cm = fine_ff; // [RULE6]
                    2'h1: cm = '{a: neg(fine_ff.b), b: fine_ff.a};
                    2'h2: cm = '{a: neg(fine_ff.a), b: neg(fine_ff.b)};
                    default: cm = '{a: fine_ff.b, b: neg(fine_ff.a)};
                endcase
            end
            COARSE_MIXER_MINUS_QTR: begin
                case (cm_cnt_d_ff)
                    2'h0: cm = fine_ff; // [RULE7]
                    2'h1: cm = '{a: fine_ff.b, b: neg(fine_ff.a)};
                    2'h2: cm = '{a: neg(fine_ff.a), b: neg(fine_ff.b)};
                    default: cm = '{a: neg(fine_ff.b), b: fine_ff.a};
                endcase
            end
            default: cm = fine_ff;
        endcase
    end

    // ---------------- inverse droop filter ----------------
    iq_sample_t tap_ff [9];
    logic sinc_v_ff;
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int k = 0; k < 9; k++) tap_ff[k] <= '0;
            sinc_v_ff <= 1'b0;
        end else begin
            sinc_v_ff <= fine_v_ff;
            if (fine_v_ff) begin
                tap_ff[0] <= cm;
                for (int k = 1; k < 9; k++) tap_ff[k] <= tap_ff[k-1];
            end
        end
    end

    logic signed [WW-1:0] fa;
    logic signed [WW-1:0] fb;
    always_comb begin
        // symmetric pairs folded before the multiply
        fa = WW'(SINC_C0 * (WW'(tap_ff[0].a) + WW'(tap_ff[8].a))) // [RULE8]
           + WW'(SINC_C1 * (WW'(tap_ff[1].a) + WW'(tap_ff[7].a)))
           + WW'(SINC_C2 * (WW'(tap_ff[2].a) + WW'(tap_ff[6].a)))
           + WW'(SINC_C3 * (WW'(tap_ff[3].a) + WW'(tap_ff[5].a)))
           + WW'(SINC_C4 * WW'(tap_ff[4].a));
        fb = WW'(SINC_C0 * (WW'(tap_ff[0].b) + WW'(tap_ff[8].b))) // [RULE8]
           + WW'(SINC_C1 * (WW'(tap_ff[1].b) + WW'(tap_ff[7].b)))
           + WW'(SINC_C2 * (WW'(tap_ff[2].b) + WW'(tap_ff[6].b)))
           + WW'(SINC_C3 * (WW'(tap_ff[3].b) + WW'(tap_ff[5].b)))
           + WW'(SINC_C4 * WW'(tap_ff[4].b));
    end
    // gain above unity: the source must back off or this stage clips // [RULE9]
    logic signed [SW-1:0] sinc_a;
    logic signed [SW-1:0] sinc_b;
    assign sinc_a = sat(fa >>> SINC_FRAC);
    assign sinc_b = sat(fb >>> SINC_FRAC);

    // ---------------- iq correction and dc shift ----------------
    logic signed [WW-1:0] gi;
    logic signed [WW-1:0] gq;
    logic signed [WW-1:0] ci;
    logic signed [WW-1:0] oa;
    logic signed [WW-1:0] ob;
    always_comb begin
        gi = WW'(sinc_a * $signed({1'b0, gain_i_ff})) >>> GAIN_FRAC; // [RULE10]
        gq = WW'(sinc_b * $signed({1'b0, gain_q_ff})) >>> GAIN_FRAC; // [RULE10]
        // skew / 4096 spans -0.125..+0.125
        ci = gi + (WW'(gq * $signed(skew_ff)) >>> SKEW_FRAC); // [RULE11]
        oa = ci + (WW'($signed(shift_a_ff)) >>> SHIFT_FRAC); // [RULE12] [RULE13]
        ob = gq + (WW'($signed(shift_b_ff)) >>> SHIFT_FRAC); // [RULE12] [RULE13]
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_out_sample <= '0;
            o_out_valid <= 1'b0;
        end else begin
            o_out_valid <= sinc_v_ff;
            if (sinc_v_ff) begin
                o_out_sample.a <= sat(oa);
                o_out_sample.b <= sat(ob);
            end
        end
    end

    // ---------------- checks ----------------
    property p_nco_load;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        nco_align |=> acc_ff == {$past(i_cfg.nco_phase), 12'h000};
    endproperty
    a_nco_load: assert property (p_nco_load) else $error("accumulator not loaded"); // [RULE21]

    property p_acc_step;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (adv && !nco_align) |=> acc_ff == $past(acc_ff) + $past(freq_ff);
    endproperty
    a_acc_step: assert property (p_acc_step) else $error("accumulator step wrong"); // [RULE23]

    property p_corr_load;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        corr_align |=> gain_i_ff == $past(i_cfg.i_path_gain)
            && skew_ff == $past(i_cfg.iq_phase_skew);
    endproperty
    a_corr_load: assert property (p_corr_load) else $error("gain not loaded"); // [RULE20]

    property p_corr_hold;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        !corr_align |=> $stable(gain_q_ff);
    endproperty
    a_corr_hold: assert property (p_corr_hold) else $error("gain changed"); // [RULE20]

    property p_shift_now;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        !i_align_ctrl.shift_needs_align |=> shift_a_ff == $past(i_cfg.a_path_dc_shift);
    endproperty
    a_shift_now: assert property (p_shift_now) else $error("shift not immediate"); // [RULE17]

    property p_shift_wait;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_align_ctrl.shift_needs_align && !shift_align) |=> $stable(shift_b_ff);
    endproperty
    a_shift_wait: assert property (p_shift_wait) else $error("shift early"); // [RULE17]

    property p_coarse_mixer_phase;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        coarse_mixer_align |=> coarse_mixer_cnt_ff == $past(i_cfg.coarse_phase);
    endproperty
    a_coarse_mixer_phase: assert property (p_coarse_mixer_phase) else $error("coarse phase"); // [RULE22]

    property p_reg_rise;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (!i_align_ctrl.tx_align_all_disable && i_align_ctrl.tx_align_source_select
            && bit_rise[5]) |-> fifo_align && nco_align;
    endproperty
    a_reg_rise: assert property (p_reg_rise) else $error("reg bit ignored"); // [RULE15]

    sequence s_pin_high;
        i_align_in_pos [*4];
    endsequence
    property p_pin_align;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (!i_align_in_pos ##1 s_pin_high) |-> ##[0:3] pin_level_ff;
    endproperty
    a_pin_align: assert property (p_pin_align) else $error("pin edge lost"); // [RULE14]

    property p_pass;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_cfg.coarse_mode == 2'h0) |-> cm == fine_ff;
    endproperty
    a_pass: assert property (p_pass) else $error("pass mode altered"); // [RULE4]
endmodule // tx_mixer_qmc_sync_chain

/* verification/sample_source.sv */
// upstream sample source: offers one held iq word at a time
// assumes the word is taken at the rising edge where valid and ready are high
`timescale 1ns/10ps
module sample_source (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_slow,
    input wire logic i_ready,
    input wire tx_chain_pkg::iq_sample_t i_level,
    output logic o_valid,
    output tx_chain_pkg::iq_sample_t o_sample
);
    import tx_chain_pkg::*;
    iq_sample_t data_ff;
    logic gap_ff;
    // caller keeps the level backed off so the droop filter cannot clip
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_valid <= 1'b0;
            gap_ff <= 1'b0;
            data_ff <= '0;
        end else if (!o_valid || i_ready) begin
            gap_ff <= ~gap_ff;
            o_valid <= !(i_slow && gap_ff);
            data_ff <= i_level;
        end
    end
    // idle word is inverted so a stale copy is never mistaken for data
    assign o_sample = o_valid ? data_ff : ~data_ff;
endmodule // sample_source

/* verification/test_tx_mixer_qmc_sync_chain.sv */
// self-checking bench for the transmit mixer / correction / align chain
// assumes a free-running upstream source model and tolerance-based compares
`timescale 1ns/10ps
module test_tx_mixer_qmc_sync_chain;
    import tx_chain_pkg::*;
    // droop taps sum to 512, so the filter is unity at dc
    localparam real FLAT = 1.0;
    localparam int K_TX = 7;
    localparam int K_FIFO = 6;
    localparam int K_CORR = 5;
    localparam int K_NCO = 4;
    localparam int K_COARSE_MIXER = 3;
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic align_pin = 1'b0;
    logic slow = 1'b0;
    logic in_valid, in_ready, out_valid, seen, hit;
    chain_cfg_t cfg;
    align_ctrl_t ctrl;
    iq_sample_t level, in_s, out_s, s0, s1;
    int bad_count = 0;
    int checked = 0;
    int k, n;
    logic [1:0] md[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
    logic [31:0] fq[5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h40000000};
    int ii[5] = '{1, -1, 0, 0, 0};
    int iq[5] = '{0, 0, -1, 1, -1};
    int qi[5] = '{0, 0, 1, -1, 1};
    int qq[5] = '{1, -1, 0, 0, 0};
    real am[5] = '{400.0, 568.8, 443.8, 443.8, 443.8};

    initial forever #12.5 i_sys_clk = ~i_sys_clk;

    sample_source src (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_slow(slow),
        .i_ready(in_ready), .i_level(level), .o_valid(in_valid), .o_sample(in_s));

    tx_mixer_qmc_sync_chain uut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .i_align_in_pos(align_pin), .i_cfg(cfg), .i_align_ctrl(ctrl),
        .i_in_valid(in_valid), .o_in_ready(in_ready), .i_in_sample(in_s),
        .o_out_valid(out_valid), .o_out_sample(out_s), .o_align_seen(seen));

    task automatic print_verdict();
        if (bad_count == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic cmp(input logic signed [11:0] got, input real want);
        real d, t;
        d = $itor(got) - want;
        t = (want < 0.0 ? -want : want) * 0.04 + 6.0;
        checked++;
        if (^got === 1'bx || d > t || d < -t) begin
            bad_count++;
            $display("BAD %0t got %h exp %h", $time, got, 12'($rtoi(want)));
        end
    endtask

    task automatic cmp_flag(input logic got, input logic want);
        checked++;
        if (got !== want) begin
            bad_count++;
            $display("BAD %0t got %h exp %h", $time, got, want);
        end
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge i_sys_clk);
    endtask

    // settle, then take the first valid output and the word one cycle later, and return on an edge
    task automatic look(output iq_sample_t a, output iq_sample_t b);
        int w;
        tick(30);
        for (w = 0; w < 20; w++) begin
            @(posedge i_sys_clk);
            #1;
            if (out_valid === 1'b1) break;
        end
        if (w == 20) begin
            bad_count++;
            print_verdict();
        end
        a = out_s;
        @(posedge i_sys_clk);
        #1;
        b = out_s;
        @(posedge i_sys_clk);
    endtask

    task automatic kick(input int idx);
        ctrl[idx] <= 1'b1;
        tick(3);
        ctrl[idx] <= 1'b0;
        tick(1);
    endtask

    function automatic logic signed [11:0] mag(input iq_sample_t s);
        return (s.a < 0 ? -s.a : s.a) + (s.b < 0 ? -s.b : s.b);
    endfunction

    initial begin
        cfg = '0;
        cfg.i_path_gain = GAIN_RESET;
        cfg.q_path_gain = GAIN_RESET;
        ctrl = '0;
        level = '{12'sh190, -12'sh12C};
        tick(6);
        i_rst_n <= 1'b1;
        slow <= 1'b1;
        look(s0, s1);
        cmp(s0.a, 400.0 * FLAT);
        cmp(s0.b, -300.0 * FLAT);
        slow <= 1'b0;
        cfg.i_path_gain <= 11'h200;
        look(s0, s1);
        cmp(s0.a, 400.0 * FLAT);
        align_pin <= 1'b1;
        for (n = 0; n < 8 && seen !== 1'b1; n++) begin
            @(posedge i_sys_clk);
            #1;
        end
        cmp_flag(seen, 1'b1);
        tick(1);
        align_pin <= 1'b0;
        look(s0, s1);
        cmp(s0.a, 200.0 * FLAT);
        cfg.a_path_dc_shift <= 13'h0640;
        look(s0, s1);
        cmp(s0.a, 200.0 * FLAT + 100.0);
        // whole control word in one update, never two writes in one step
        ctrl <= '{tx_align_source_select: 1'b1, shift_needs_align: 1'b1, default: 1'b0};
        cfg.b_path_dc_shift <= 13'h19C0;
        look(s0, s1);
        cmp(s0.b, -300.0 * FLAT);
        kick(K_TX);
        look(s0, s1);
        cmp(s0.b, -300.0 * FLAT - 100.0);
        ctrl <= '{tx_align_all_disable: 1'b1, default: 1'b0};
        cfg.a_path_dc_shift <= '0;
        cfg.b_path_dc_shift <= '0;
        tick(1);
        // fifo before the rest, as the block order demands
        ctrl[K_FIFO] <= 1'b1;
        hit = 1'b0;
        for (n = 0; n < 4; n++) begin
            @(posedge i_sys_clk);
            #1;
            if (in_ready === 1'b0) hit = 1'b1;
        end
        cmp_flag(hit, 1'b1);
        tick(1);
        ctrl[K_FIFO] <= 1'b0;
        cfg.i_path_gain <= GAIN_RESET;
        cfg.iq_phase_skew <= 10'h1FF;
        tick(1);
        kick(K_CORR);
        look(s0, s1);
        cmp(s0.a, (400.0 - 511.0 * 300.0 / 4096.0) * FLAT);
        cmp(s0.b, -300.0 * FLAT);
        cfg.iq_phase_skew <= SKEW_RESET;
        level <= '{12'sh190, 12'sh000};
        tick(1);
        kick(K_CORR);
        for (k = 0; k < 5; k++) begin
            cfg.coarse_mode <= md[k];
            cfg.nco_freq <= fq[k];
            // vary the restart index so the coarse phase load is exercised
            cfg.coarse_phase <= 2'(k);
            tick(1);
            kick(K_NCO);
            kick(K_COARSE_MIXER);
            look(s0, s1);
            cmp(s1.a, ii[k] * $itor(s0.a) + iq[k] * $itor(s0.b));
            cmp(s1.b, qi[k] * $itor(s0.a) + qq[k] * $itor(s0.b));
            cmp(mag(s0), am[k]);
        end
        print_verdict();
    end
endmodule // test_tx_mixer_qmc_sync_chain
